// ===== pkg/led_pwm_pkg.sv
// Constants and types for the eight-channel LED PWM core
package led_pwm_pkg;
    localparam int CHANNELS = 8;
    localparam int CODE_WIDTH = 8;
    localparam logic [7:0] PERIOD_LAST = 8'hFE;
    localparam logic [7:0] CODE_FULL_ON = 8'hFF;
    localparam logic [7:0] CODE_OFF = 8'h00;
    localparam logic [7:0] CODE_RESET = 8'hFF;
    localparam logic [7:0] COUNT_START = 8'h00;
    localparam int PWM_TICK_DIV = 40;

    typedef struct packed {
        logic above_upper;
        logic below_lower;
    } thermal_flags_t;

    typedef struct packed {
        logic load;
        logic [2:0] channel;
        logic [7:0] code;
    } code_load_t;

    typedef enum logic {THERM_RUN, THERM_SHUTDOWN} therm_state_t;
endpackage : led_pwm_pkg

// ===== rtl/eight_channel_led_pwm_core.sv
// Top of the eight-channel LED PWM core
`timescale 1ns/10ps
`default_nettype none
module eight_channel_led_pwm_core
    import led_pwm_pkg::*;
#(
    parameter int TICK_DIV = PWM_TICK_DIV
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic output_enable_in,
    input wire thermal_flags_t thermal_in,
    input wire code_load_t code_load,
    output logic [CHANNELS-1:0] led_on,
    output logic thermal_shutdown,
    output logic pwm_tick_clock
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic oe_sync;
    thermal_flags_t therm_sync;

    assign oe_sync = sync_b[0];
    assign therm_sync = thermal_flags_t'(sync_b[2:1]);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end
        else if (clk_en)
        begin
            sync_a <= {thermal_in, output_enable_in};
            sync_b <= sync_a;
        end
    end

    // ****************************************
    // PWM tick and shared period counter
    // ****************************************
    logic [15:0] div_count;
    logic [7:0] count;
    logic tick;
    logic period_start;
    logic [7:0] next_count;

    assign tick = (div_count == 16'(TICK_DIV - 1));
    assign period_start = (count == PERIOD_LAST);
    assign next_count = period_start ? COUNT_START : count + 8'h01;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            div_count <= 16'h0000;
            count <= COUNT_START;
            pwm_tick_clock <= 1'b0;
        end
        else if (clk_en)
        begin
            div_count <= tick ? 16'h0000 : div_count + 16'h0001;
            pwm_tick_clock <= tick;
            if (tick)
                count <= next_count;
        end
    end

    // ****************************************
    // Thermal shutdown with hysteresis
    // ****************************************
    therm_state_t state;
    therm_state_t next_state;

    always_comb
    begin
        next_state = state;
        unique case (state)
            THERM_RUN:
                if (therm_sync.above_upper)
                    next_state = THERM_SHUTDOWN;
            THERM_SHUTDOWN:
                if (therm_sync.below_lower && !therm_sync.above_upper)
                    next_state = THERM_RUN;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            state <= THERM_RUN;
        else if (clk_en)
            state <= next_state;
    end

    assign thermal_shutdown = (state == THERM_SHUTDOWN);

    // ****************************************
    // Channels
    // ****************************************
    logic gate_on;
    logic loaded_recently;

    // Reset brings outputs on until an enable or a code load is seen
    assign gate_on = (oe_sync || !loaded_recently) && !thermal_shutdown;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            loaded_recently <= 1'b0;
        else if (clk_en && (oe_sync || code_load.load))
            loaded_recently <= 1'b1;
    end

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_ch
        pwm_channel u_ch (
            .ref_clk(ref_clk),
            .reset(reset),
            .clk_en(clk_en),
            .tick(tick),
            .period_start(period_start),
            .count(count),
            .load(code_load.load && code_load.channel == 3'(ch)),
            .load_code(code_load.code),
            .gate_on(gate_on),
            .pwm_out(led_on[ch])
        );
    end
endmodule : eight_channel_led_pwm_core
`default_nettype wire

// ===== rtl/pwm_channel.sv
// One PWM channel: pending code, active code and comparator
`timescale 1ns/10ps
`default_nettype none
module pwm_channel
    import led_pwm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic period_start,
    input wire logic [7:0] count,
    input wire logic load,
    input wire logic [7:0] load_code,
    input wire logic gate_on,
    output logic pwm_out
);
    logic [7:0] pending_code;
    logic [7:0] active_code;
    logic next_on;

    // Unsigned compare gives code ticks per 255-tick period
    assign next_on = gate_on && (active_code == CODE_FULL_ON || count < active_code);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pending_code <= CODE_RESET;
            active_code <= CODE_RESET;
            pwm_out <= 1'b0;
        end
        else if (clk_en)
        begin
            if (load)
                pending_code <= load_code;
            // Swap only at period start, avoiding runt pulses
            if (tick && period_start)
                active_code <= pending_code;
            pwm_out <= next_on;
        end
    end
endmodule : pwm_channel
`default_nettype wire

// ===== verif/dimming_ctl.sv
// Controller model loading luminance codes
`timescale 1ns/10ps
`default_nettype none
module dimming_ctl
    import led_pwm_pkg::*;
(
    input wire logic ref_clk,
    output var code_load_t code_load = '0
);
    task send(logic [2:0] ch, logic [7:0] d);
        @(posedge ref_clk);
        code_load <= {1'b1, ch, d};
        @(posedge ref_clk);
        code_load <= {1'b0, ~ch, ~d};
    endtask : send
endmodule : dimming_ctl
`default_nettype wire

// ===== verif/eight_channel_led_pwm_core_test.sv
// Testbench of the LED PWM core
`timescale 1ns/10ps
`default_nettype none
module eight_channel_led_pwm_core_test;
    import led_pwm_pkg::*;
    logic ref_clk = 0, reset = 1, clk_en = 1, output_enable_in = 1;
    logic thermal_shutdown, pwm_tick_clock;
    logic [7:0] led_on, codes [8];
    thermal_flags_t thermal_in = '0;
    code_load_t code_load;
    int err_count = 0, n_compared = 0, hits [8];
    always #2.5 ref_clk = ~ref_clk;
    dimming_ctl u_ctl (.*);
    eight_channel_led_pwm_core #(.TICK_DIV(2)) u_dut (.*);
    task check(string s, logic [8:0] e, logic [8:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", s, e, g);
        end
    endtask : check
    task final_report;
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task heat(thermal_flags_t t, logic v);
        @(posedge ref_clk);
        thermal_in <= t;
        for (int n = 0; n < 20 && thermal_shutdown !== v; n++) @(negedge ref_clk);
        repeat (5) @(negedge ref_clk);
        check("shutdown", 9'(v), 9'(thermal_shutdown));
    endtask : heat
    initial
    begin
        void'($urandom(32'h27ECC54B));
        repeat (20) @(posedge ref_clk);
        reset <= 0;
        for (int r = 0; r < 3; r++)
        begin
            foreach (codes[c])
            begin
                codes[c] = r ? 8'($urandom) : 8'(c[0] ? 255 - c / 2 : c / 2);
                u_ctl.send(3'(c), codes[c]);
            end
            hits = '{default: 0};
            repeat (1530) @(negedge ref_clk);
            repeat (510) @(negedge ref_clk) foreach (hits[c]) hits[c] += led_on[c];
            foreach (hits[c]) check("duty", 9'(codes[c] * 2), 9'(hits[c]));
        end
        heat(2'b10, 1);
        check("dark", 0, led_on);
        heat(2'b00, 1);
        heat(2'b01, 0);
        @(posedge ref_clk);
        output_enable_in <= 0;
        repeat (6) @(negedge ref_clk);
        check("gated", 0, led_on);
        final_report();
    end
endmodule : eight_channel_led_pwm_core_test
`default_nettype wire

// ===== verif/led_pwm_monitor.sv
// Port checker of the LED PWM core
`timescale 1ns/10ps
`default_nettype none
module led_pwm_monitor
    import led_pwm_pkg::*;
#(parameter int TICK_DIV = 2)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic output_enable_in,
    input wire thermal_flags_t thermal_in,
    input wire logic [CHANNELS-1:0] led_on,
    input wire logic thermal_shutdown,
    input wire logic pwm_tick_clock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_hot; thermal_in.above_upper [*4]; endsequence
    sequence s_cool; (thermal_in.below_lower && !thermal_in.above_upper) [*4]; endsequence
    property p_gap; pwm_tick_clock |=> !pwm_tick_clock; endproperty
    a_gap: assert property (p_gap) else $error("wide tick");
    property p_due; pwm_tick_clock |-> ##[1:40] pwm_tick_clock; endproperty
    a_due: assert property (p_due) else $error("tick lost");
    property p_up; $fell(reset) |=> led_on == 8'hFF; endproperty
    a_up: assert property (p_up) else $error("dark start");
    property p_hot; s_hot |-> thermal_shutdown; endproperty
    a_hot: assert property (p_hot) else $error("no stop");
    property p_off; thermal_shutdown [*3] |-> led_on == 8'h00; endproperty
    a_off: assert property (p_off) else $error("lit hot");
    property p_hold; (thermal_shutdown && !thermal_in.below_lower) [*4] |=> thermal_shutdown; endproperty
    a_hold: assert property (p_hold) else $error("early release");
    property p_cool; s_cool |=> !thermal_shutdown; endproperty
    a_cool: assert property (p_cool) else $error("stuck off");
    property p_oe; output_enable_in [*3] ##1 !output_enable_in [*5] |-> led_on == 8'h00; endproperty
    a_oe: assert property (p_oe) else $error("lit gated");
endmodule : led_pwm_monitor
bind eight_channel_led_pwm_core led_pwm_monitor #(.TICK_DIV(TICK_DIV)) u_mon (.*);
`default_nettype wire
